/* rtl/cpu_exception_context_regs.sv */
// exception context registers of the processor core
// assumes the pipeline gives one-cycle strobes on clk_sys
//
// What this block does
// [RL1] state bit 16 gates external and timer interrupts
// [RL2] state bit 17 selects user or supervisor
// [RL3] state bit 19 enables machine checks
// [RL4] bits 21, 22 enable debug wait, interrupts
// [RL5] bits 26, 27 turn address translation on
// [RL6] noncritical entry saves pc and state
// [RL7] noncritical return restores pc and state
// [RL8] save pc registers hold bits 0:29
// [RL9] saved state registers copy whole state
// [RL10] critical entry saves pc and state
// [RL11] critical return restores pc and state
// [RL12] critical entry other than machine check keeps machine check enable
// [RL13] handler address is prefix then offset
// [RL14] move instructions read and write registers
// [RL15] syndrome bit 0 flags ifetch machine check
// [RL16] syndrome bits 4-6 flag program causes
// [RL17] bits 8, 9, 16 flag storage faults
// [RL18] storage, program faults keep only ifetch flag
// [RL19] enabled ifetch check sets flag, clears others
// [RL20] disabled ifetch check sets flag only
// [RL21] disabled check plus fault sets both
// [RL22] translation miss clears all but ifetch flag
// [RL23] data faults record effective address
// [RL24] state bit 14 gates critical and watchdog
// [RL25] restored pc has low bits zero

`timescale 1ns/1ps

module cpu_exception_context_regs (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    // move instruction access
    input  wire exc_ctx_pkg::spr_sel_t   spr_sel,
    input  wire logic                    spr_wr,
    input  wire logic                    spr_rd,
    input  wire logic [31:0]             spr_wdata,
    output logic      [31:0]             spr_rdata,
    output logic                         spr_rvalid,
    // interrupt entry from pipeline
    input  wire logic                    take_noncrit,
    input  wire logic                    take_crit,
    input  wire logic                    take_is_mcheck,
    input  wire logic [31:0]             take_pc,
    input  wire logic [15:0]             take_vec_offset,
    input  wire logic [31:0]             take_state_clr,
    output logic      [31:0]             handler_addr,
    output logic                         handler_valid,
    // return instructions
    input  wire logic                    ret_noncrit,
    input  wire logic                    ret_crit,
    output logic      [31:0]             resume_pc,
    output logic                         resume_valid,
    // fault causes
    input  wire exc_ctx_pkg::fault_kind_t fault_kind,
    input  wire logic                    illegal_op_flag,
    input  wire logic                    priv_op_flag,
    input  wire logic                    trap_hit_flag,
    input  wire logic                    store_fault_flag,
    input  wire logic                    zone_fault_flag,
    input  wire logic                    user0_fault_flag,
    input  wire logic [31:0]             fault_ea,
    input  wire logic                    ifetch_mcheck_hit,
    output logic                         ifetch_mcheck_take,
    // raw interrupt requests
    input  wire logic                    ext_int_req,
    input  wire logic                    periodic_timer_req,
    input  wire logic                    fixed_timer_req,
    input  wire logic                    crit_int_req,
    input  wire logic                    watchdog_req,
    // gated requests and mode bits
    output logic                         ext_int_allowed,
    output logic                         periodic_timer_allowed,
    output logic                         fixed_timer_allowed,
    output logic                         crit_int_allowed,
    output logic                         watchdog_allowed,
    output logic                         user_state_flag,
    output logic                         mcheck_enable,
    output logic                         dbg_wait_enable,
    output logic                         dbg_int_enable,
    output logic                         instr_translate_on,
    output logic                         data_translate_on
);

    // ==========
    // registers
    logic [31:0] machine_state_r;              // current state word
    logic [31:0] machine_state_nxt;
    logic [31:2] noncrit_save_pc_r;            // noncritical pc
    logic [31:0] noncrit_save_state_r;         // noncritical state
    logic [31:2] crit_save_pc_r;               // critical pc
    logic [31:0] crit_save_state_r;            // critical state
    logic [15:0] vector_prefix_r;              // handler prefix
    logic [31:0] syndrome_reg_r;               // fault syndrome
    logic [31:0] syndrome_nxt;
    logic [31:0] data_fault_addr_r;            // faulting address
    logic [31:0] spr_rdata_r;                  // read data
    logic        spr_rvalid_r;                 // read strobe
    logic [31:0] handler_addr_r;               // vector address
    logic        handler_valid_r;              // vector strobe
    logic [31:0] resume_pc_r;                  // return address
    logic        resume_valid_r;               // return strobe

    // ==========
    // selector decode
    // true when a write targets the given register
    function automatic logic wr_hit(
        input exc_ctx_pkg::spr_sel_t sel,
        input exc_ctx_pkg::spr_sel_t code,
        input logic                  wr
    );
        wr_hit = wr && (sel == code);
    endfunction : wr_hit

    wire w_state  = wr_hit(spr_sel, exc_ctx_pkg::SEL_STATE, spr_wr);
    wire w_nc_pc  = wr_hit(spr_sel, exc_ctx_pkg::SEL_NC_PC, spr_wr);
    wire w_nc_st  = wr_hit(spr_sel, exc_ctx_pkg::SEL_NC_ST, spr_wr);
    wire w_cr_pc  = wr_hit(spr_sel, exc_ctx_pkg::SEL_CR_PC, spr_wr);
    wire w_cr_st  = wr_hit(spr_sel, exc_ctx_pkg::SEL_CR_ST, spr_wr);
    wire w_prefix = wr_hit(spr_sel, exc_ctx_pkg::SEL_PREFIX, spr_wr);
    wire w_synd   = wr_hit(spr_sel, exc_ctx_pkg::SEL_SYND, spr_wr);
    wire w_faddr  = wr_hit(spr_sel, exc_ctx_pkg::SEL_FADDR, spr_wr);

    // ==========
    // state word fields
    wire ee_bit = machine_state_r[exc_ctx_pkg::EE_BIT];
    wire ce_bit = machine_state_r[exc_ctx_pkg::CE_BIT];
    wire me_bit = machine_state_r[exc_ctx_pkg::ME_BIT];

    // external, periodic and fixed timer gated together
    assign ext_int_allowed        = ext_int_req & ee_bit;        // see [RL1]
    assign periodic_timer_allowed = periodic_timer_req & ee_bit; // see [RL1]
    assign fixed_timer_allowed    = fixed_timer_req & ee_bit;    // see [RL1]
    // critical input and first watchdog timeout
    assign crit_int_allowed       = crit_int_req & ce_bit;       // see [RL24]
    assign watchdog_allowed       = watchdog_req & ce_bit;       // see [RL24]
    // mode bits straight from the state register
    assign user_state_flag    = machine_state_r[exc_ctx_pkg::PR_BIT];  // see [RL2]
    assign mcheck_enable      = me_bit;                                // see [RL3]
    assign dbg_wait_enable    = machine_state_r[exc_ctx_pkg::DWE_BIT]; // see [RL4]
    assign dbg_int_enable     = machine_state_r[exc_ctx_pkg::DE_BIT];  // see [RL4]
    assign instr_translate_on = machine_state_r[exc_ctx_pkg::IR_BIT];  // see [RL5]
    assign data_translate_on  = machine_state_r[exc_ctx_pkg::DR_BIT];  // see [RL5]

    // ==========
    // machine check qualification
    // only an enabled ifetch check is taken
    assign ifetch_mcheck_take = ifetch_mcheck_hit & me_bit; // see [RL3]
    // disabled check is only recorded
    wire mci_quiet = ifetch_mcheck_hit & ~me_bit;

    // ==========
    // state word next value
    // plain critical entry spares the enable
    wire [31:0] crit_clr = take_is_mcheck ? take_state_clr :
        (take_state_clr & ~(32'h00000001 << exc_ctx_pkg::ME_BIT)); // see [RL12]
    wire [31:0] entry_clr = take_crit ? crit_clr : take_state_clr;

    // entry beats return, return beats a software move
    always_comb begin
        machine_state_nxt = machine_state_r;
        if (take_crit || take_noncrit) begin
            machine_state_nxt = machine_state_r & ~entry_clr;
        end else if (ret_crit) begin
            machine_state_nxt = crit_save_state_r;    // see [RL11]
        end else if (ret_noncrit) begin
            machine_state_nxt = noncrit_save_state_r; // see [RL7]
        end else if (w_state) begin
            machine_state_nxt = spr_wdata;            // see [RL14]
        end
    end

    // state word register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            machine_state_r <= exc_ctx_pkg::RST_WORD;
        end else begin
            machine_state_r <= machine_state_nxt;
        end
    end

    // ==========
    // noncritical save pair
    // entry wins over a move in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            noncrit_save_pc_r    <= exc_ctx_pkg::RST_WORD[31:2];
            noncrit_save_state_r <= exc_ctx_pkg::RST_WORD;
        end else if (take_noncrit && !take_crit) begin
            noncrit_save_pc_r    <= take_pc[31:2];   // see [RL6] [RL8]
            noncrit_save_state_r <= machine_state_r; // see [RL6] [RL9]
        end else begin
            if (w_nc_pc) begin
                noncrit_save_pc_r <= spr_wdata[31:2]; // see [RL14] [RL8]
            end
            if (w_nc_st) begin
                noncrit_save_state_r <= spr_wdata;    // see [RL14]
            end
        end
    end

    // ==========
    // critical save pair
    // a machine check here overwrites unsaved context
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            crit_save_pc_r    <= exc_ctx_pkg::RST_WORD[31:2];
            crit_save_state_r <= exc_ctx_pkg::RST_WORD;
        end else if (take_crit) begin
            crit_save_pc_r    <= take_pc[31:2];   // see [RL10] [RL8] [RL12]
            crit_save_state_r <= machine_state_r; // see [RL10] [RL9]
        end else begin
            if (w_cr_pc) begin
                crit_save_pc_r <= spr_wdata[31:2]; // see [RL14] [RL8]
            end
            if (w_cr_st) begin
                crit_save_state_r <= spr_wdata;    // see [RL14]
            end
        end
    end

    // ==========
    // vector prefix and handler address
    // only the prefix field is stored
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            vector_prefix_r <= exc_ctx_pkg::RST_WORD[31:16];
        end else if (w_prefix) begin
            vector_prefix_r <= spr_wdata[31:exc_ctx_pkg::PFX_LSB]; // see [RL14]
        end
    end

    // prefix on the left, offset on the right
    wire [31:0] vec_addr = {vector_prefix_r, take_vec_offset}; // see [RL13]
    wire        entering = take_crit | take_noncrit;

    // handler address with its strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            handler_addr_r  <= exc_ctx_pkg::RST_WORD;
            handler_valid_r <= 1'b0;
        end else begin
            handler_valid_r <= entering;
            if (entering) begin
                handler_addr_r <= vec_addr; // see [RL13]
            end
        end
    end

    // ==========
    // return address
    // low bits forced to zero for word alignment
    wire [31:0] nc_resume = {noncrit_save_pc_r, exc_ctx_pkg::PC_PAD}; // see [RL25]
    wire [31:0] cr_resume = {crit_save_pc_r, exc_ctx_pkg::PC_PAD};    // see [RL25]
    wire        returning = (ret_crit | ret_noncrit) & ~entering;

    // resume address with its strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            resume_pc_r    <= exc_ctx_pkg::RST_WORD;
            resume_valid_r <= 1'b0;
        end else begin
            resume_valid_r <= returning;
            if (returning) begin
                resume_pc_r <= ret_crit ? cr_resume : nc_resume; // see [RL7] [RL11]
            end
        end
    end

    // ==========
    // syndrome update
    // cause bits gathered by group
    logic [31:0] prog_bits;
    logic [31:0] dsi_bits;
    logic [31:0] mci_one;
    always_comb begin
        prog_bits = exc_ctx_pkg::RST_WORD;
        dsi_bits  = exc_ctx_pkg::RST_WORD;
        mci_one   = exc_ctx_pkg::RST_WORD;
        prog_bits[exc_ctx_pkg::PIL_BIT] = illegal_op_flag;  // see [RL16]
        prog_bits[exc_ctx_pkg::PPR_BIT] = priv_op_flag;     // see [RL16]
        prog_bits[exc_ctx_pkg::PTR_BIT] = trap_hit_flag;    // see [RL16]
        dsi_bits[exc_ctx_pkg::DST_BIT]  = store_fault_flag; // see [RL17]
        dsi_bits[exc_ctx_pkg::DIZ_BIT]  = zone_fault_flag;  // see [RL17]
        dsi_bits[exc_ctx_pkg::U0F_BIT]  = user0_fault_flag; // see [RL17]
        mci_one[exc_ctx_pkg::MCI_BIT]   = 1'b1;             // see [RL15]
    end

    // ifetch flag kept, all else rebuilt
    wire [31:0] mci_kept = syndrome_reg_r & mci_one;

    // hardware update beats a software move
    always_comb begin
        syndrome_nxt = w_synd ? spr_wdata : syndrome_reg_r; // see [RL14]
        unique case (fault_kind)
            exc_ctx_pkg::FLT_PROGRAM: begin
                syndrome_nxt = mci_kept | prog_bits; // see [RL18]
            end
            exc_ctx_pkg::FLT_DSTORE: begin
                syndrome_nxt = mci_kept | dsi_bits;  // see [RL18]
            end
            exc_ctx_pkg::FLT_DTLB: begin
                syndrome_nxt = mci_kept;             // see [RL22]
            end
            exc_ctx_pkg::FLT_ISTORE: begin
                syndrome_nxt = mci_kept | (dsi_bits & (32'h00000001 << exc_ctx_pkg::DIZ_BIT));
            end
            exc_ctx_pkg::FLT_NONE,
            exc_ctx_pkg::FLT_ALIGN: begin
                // alignment leaves the syndrome alone
            end
            default: begin
                // undefined codes change nothing
            end
        endcase
        if (ifetch_mcheck_take) begin
            syndrome_nxt = mci_one;                  // see [RL19]
        end else if (mci_quiet) begin
            syndrome_nxt = syndrome_nxt | mci_one;   // see [RL20] [RL21]
        end
    end

    // syndrome register, reserved bits held at zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            syndrome_reg_r <= exc_ctx_pkg::RST_WORD;
        end else begin
            syndrome_reg_r <= syndrome_nxt & exc_ctx_pkg::SYN_MASK; // see [RL15]
        end
    end

    // ==========
    // faulting data address
    wire ea_capture = (fault_kind == exc_ctx_pkg::FLT_ALIGN) ||
                      (fault_kind == exc_ctx_pkg::FLT_DTLB)  ||
                      (fault_kind == exc_ctx_pkg::FLT_DSTORE);

    // fault capture wins over a move
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            data_fault_addr_r <= exc_ctx_pkg::RST_WORD;
        end else if (ea_capture) begin
            data_fault_addr_r <= fault_ea;  // see [RL23]
        end else if (w_faddr) begin
            data_fault_addr_r <= spr_wdata; // see [RL14]
        end
    end

    // ==========
    // register read
    logic [31:0] rd_mux;
    always_comb begin
        unique case (spr_sel)
            exc_ctx_pkg::SEL_STATE:  rd_mux = machine_state_r;
            exc_ctx_pkg::SEL_NC_PC:  rd_mux = {noncrit_save_pc_r, exc_ctx_pkg::PC_PAD};
            exc_ctx_pkg::SEL_NC_ST:  rd_mux = noncrit_save_state_r;
            exc_ctx_pkg::SEL_CR_PC:  rd_mux = {crit_save_pc_r, exc_ctx_pkg::PC_PAD};
            exc_ctx_pkg::SEL_CR_ST:  rd_mux = crit_save_state_r;
            exc_ctx_pkg::SEL_PREFIX: rd_mux = {vector_prefix_r, exc_ctx_pkg::RST_WORD[15:0]};
            exc_ctx_pkg::SEL_SYND:   rd_mux = syndrome_reg_r;
            exc_ctx_pkg::SEL_FADDR:  rd_mux = data_fault_addr_r;
            default:                 rd_mux = exc_ctx_pkg::RST_WORD;
        endcase
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            spr_rdata_r  <= exc_ctx_pkg::RST_WORD;
            spr_rvalid_r <= 1'b0;
        end else begin
            spr_rvalid_r <= spr_rd;
            if (spr_rd) begin
                spr_rdata_r <= rd_mux; // see [RL14]
            end
        end
    end

    // ==========
    // outputs
    assign spr_rdata     = spr_rdata_r;
    assign spr_rvalid    = spr_rvalid_r;
    assign handler_addr  = handler_addr_r;
    assign handler_valid = handler_valid_r;
    assign resume_pc     = resume_pc_r;
    assign resume_valid  = resume_valid_r;

endmodule : cpu_exception_context_regs

/* rtl/exc_ctx_pkg.sv */
// constants and types for the exception context block
// assumes bit 0 of every register is its least significant bit

package exc_ctx_pkg;

    // ==========
    // state word bit positions
    localparam int CE_BIT  = 17; // critical enable
    localparam int EE_BIT  = 15; // async interrupt enable
    localparam int PR_BIT  = 14; // user state flag
    localparam int ME_BIT  = 12; // machine check enable
    localparam int DWE_BIT = 10; // debug wait enable
    localparam int DE_BIT  = 9;  // debug interrupt enable
    localparam int IR_BIT  = 5;  // instr translation on
    localparam int DR_BIT  = 4;  // data translation on

    // ==========
    // syndrome bit positions
    localparam int MCI_BIT = 31; // ifetch machine check
    localparam int PIL_BIT = 27; // illegal op
    localparam int PPR_BIT = 26; // privileged op
    localparam int PTR_BIT = 25; // trap hit
    localparam int DST_BIT = 23; // store fault
    localparam int DIZ_BIT = 22; // zone fault
    localparam int U0F_BIT = 15; // user0 fault

    // implemented syndrome bits
    localparam logic [31:0] SYN_MASK = 32'h8EC08000;

    // ==========
    // field layouts and reset values
    localparam int PC_LSB   = 2;  // save pc holds [31:2]
    localparam int PFX_LSB  = 16; // prefix field low bit
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [1:0]  PC_PAD   = 2'h0;

    // ==========
    // register selector for move instructions
    typedef enum logic [2:0] {
        SEL_STATE,   // machine_state_word
        SEL_NC_PC,   // noncritical_return_address
        SEL_NC_ST,   // noncritical_saved_state
        SEL_CR_PC,   // critical_return_address
        SEL_CR_ST,   // critical_saved_state
        SEL_PREFIX,  // handler_vector_prefix
        SEL_SYND,    // fault_syndrome
        SEL_FADDR    // faulting_data_address
    } spr_sel_t;

    // fault reported by the pipeline
    typedef enum logic [2:0] {
        FLT_NONE,
        FLT_PROGRAM,
        FLT_DSTORE,
        FLT_DTLB,
        FLT_ISTORE,
        FLT_ALIGN
    } fault_kind_t;

endpackage : exc_ctx_pkg

/* verification/core_pc_model.sv */
// program counter of the core, far side of the return path
// assumes resume_valid is a one-cycle strobe on clk_sys
`timescale 1ns/1ps
module core_pc_model (
    input wire logic clk_sys, resetn, resume_valid,
    input wire logic [31:0] resume_pc,
    output logic [31:0] core_pc
);
    // jumps to the resume target, else steps one word
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) core_pc <= 32'h00000000;
        else if (resume_valid) core_pc <= resume_pc;
        else core_pc <= core_pc + 32'h00000004;
    end
endmodule : core_pc_model

/* verification/exc_ctx_properties.sv */
// checker for the exception context block
// assumes it is bound to cpu_exception_context_regs
`timescale 1ns/1ps
module exc_ctx_properties (
    input wire logic clk_sys, resetn, spr_wr, spr_rd, spr_rvalid,
    input wire exc_ctx_pkg::spr_sel_t spr_sel,
    input wire logic [31:0] spr_wdata, spr_rdata, handler_addr, resume_pc,
    input wire logic take_noncrit, take_crit, take_is_mcheck, handler_valid,
    input wire logic [15:0] take_vec_offset,
    input wire logic ret_noncrit, ret_crit, resume_valid, mcheck_enable,
    input wire logic ifetch_mcheck_hit, ifetch_mcheck_take, user_state_flag,
    input wire logic ext_int_req, ext_int_allowed, crit_int_req, crit_int_allowed
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ==========
    // sequences
    wire ent = take_noncrit | take_crit; // any entry this cycle
    sequence s_state_wr; // unopposed state write
        spr_wr && spr_sel == exc_ctx_pkg::SEL_STATE && !ent && !ret_noncrit && !ret_crit;
    endsequence
    sequence s_ret; // lone return
        (ret_noncrit || ret_crit) && !ent;
    endsequence
    chk_ext_gate: assert property (s_state_wr |=>
        ext_int_allowed == (ext_int_req && $past(spr_wdata[15]))) else $error("ext gate wrong");
    chk_user_bit: assert property (s_state_wr |=>
        user_state_flag == $past(spr_wdata[14])) else $error("user bit wrong");
    chk_crit_gate: assert property (s_state_wr |=>
        crit_int_allowed == (crit_int_req && $past(spr_wdata[17]))) else $error("crit gate wrong");
    chk_mci_take: assert property (ifetch_mcheck_hit |->
        ifetch_mcheck_take == mcheck_enable) else $error("mcheck take wrong");
    chk_me_kept: assert property (take_crit && !take_is_mcheck && mcheck_enable |=>
        mcheck_enable) else $error("me cleared");
    chk_vec_addr: assert property (ent |=>
        handler_valid && handler_addr[15:0] == $past(take_vec_offset)) else $error("vector wrong");
    chk_resume_word: assert property (s_ret |=>
        resume_valid && resume_pc[1:0] == 2'h0) else $error("resume wrong");
    chk_read_answer: assert property (spr_rd |=> spr_rvalid) else $error("no read answer");
    chk_prefix_low: assert property (spr_rd && spr_sel == exc_ctx_pkg::SEL_PREFIX |=>
        spr_rdata[15:0] == 16'h0000) else $error("prefix low bits set");
endmodule : exc_ctx_properties
bind cpu_exception_context_regs exc_ctx_properties u_exc_ctx_properties (.*);

/* verification/tb.sv */
// testbench of the exception context block
// assumes design and core_pc_model compile first
`timescale 1ns/1ps
module tb;
    logic clk_sys, resetn, spr_wr, spr_rd, take_noncrit, take_crit, take_is_mcheck;
    logic ret_noncrit, ret_crit, ifetch_mcheck_hit, illegal_op_flag, priv_op_flag;
    logic trap_hit_flag, store_fault_flag, zone_fault_flag, user0_fault_flag;
    logic [31:0] spr_wdata, take_pc, take_state_clr, fault_ea, spr_rdata;
    logic [31:0] handler_addr, resume_pc, core_pc;
    logic [15:0] take_vec_offset;
    logic [4:0] reqs;
    logic spr_rvalid, handler_valid, resume_valid, ifetch_mcheck_take, ext_int_allowed;
    logic periodic_timer_allowed, fixed_timer_allowed, crit_int_allowed, watchdog_allowed;
    logic user_state_flag, mcheck_enable, dbg_wait_enable, dbg_int_enable;
    logic instr_translate_on, data_translate_on;
    wire ext_int_req, periodic_timer_req, fixed_timer_req, crit_int_req, watchdog_req;
    exc_ctx_pkg::spr_sel_t spr_sel;
    exc_ctx_pkg::fault_kind_t fault_kind;
    int miscompares, checks;
    logic [31:0] masks [8] = '{32'hFFFFFFFF, 32'hFFFFFFFC, 32'hFFFFFFFF, 32'hFFFFFFFC,
                               32'hFFFFFFFF, 32'hFFFF0000, 32'h8EC08000, 32'hFFFFFFFF};
    assign {ext_int_req, periodic_timer_req, fixed_timer_req, crit_int_req, watchdog_req} = reqs;
    wire [3:0] modes = {dbg_wait_enable, dbg_int_enable, instr_translate_on, data_translate_on};
    wire [4:0] gates = {ext_int_allowed, periodic_timer_allowed, fixed_timer_allowed,
                        crit_int_allowed, watchdog_allowed};
    cpu_exception_context_regs u_cpu_exception_context_regs (.*);
    core_pc_model u_core_pc_model (.*);
    // ==========
    // clock, requests and helpers
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) reqs <= reqs + 5'h01; // raw requests keep toggling
    task automatic check(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic idle(); // drop strobes at the taking edge
        @(posedge clk_sys);
        {spr_wr, spr_rd, take_noncrit, take_crit, ret_noncrit, ret_crit, ifetch_mcheck_hit} <= '0;
        fault_kind <= exc_ctx_pkg::FLT_NONE;
        #1;
    endtask : idle
    task automatic wr(input exc_ctx_pkg::spr_sel_t s, input logic [31:0] d);
        @(posedge clk_sys);
        spr_sel <= s; spr_wdata <= d; spr_wr <= 1'b1;
        idle();
    endtask : wr
    task automatic rd(input string what, input exc_ctx_pkg::spr_sel_t s, input logic [31:0] e);
        @(posedge clk_sys);
        spr_sel <= s; spr_rd <= 1'b1;
        idle();
        check(what, e, spr_rdata);
    endtask : rd
    // ==========
    // scenarios
    task automatic t_map(); // reset, then all ones
        for (int i = 0; i < 8; i++) begin
            rd("reset value", exc_ctx_pkg::spr_sel_t'(i), 32'h00000000);
            wr(exc_ctx_pkg::spr_sel_t'(i), 32'hFFFFFFFF);
            rd("writable bits", exc_ctx_pkg::spr_sel_t'(i), masks[i]);
        end
    endtask : t_map
    task automatic t_entry(input logic crit); // entry, save, return
        wr(exc_ctx_pkg::SEL_STATE, 32'h00029000);
        @(posedge clk_sys);
        take_crit <= crit; take_noncrit <= !crit; take_is_mcheck <= 1'b0;
        take_pc <= 32'h00001237; take_vec_offset <= 16'h0700; take_state_clr <= 32'hFFFFFFFF;
        idle();
        check("handler", 32'hFFFF0700, handler_addr);
        rd("save pc", crit ? exc_ctx_pkg::SEL_CR_PC : exc_ctx_pkg::SEL_NC_PC, 32'h1234);
        rd("save state", crit ? exc_ctx_pkg::SEL_CR_ST : exc_ctx_pkg::SEL_NC_ST, 32'h29000);
        rd("entry state", exc_ctx_pkg::SEL_STATE, crit ? 32'h1000 : 32'h0);
        @(posedge clk_sys);
        ret_crit <= crit; ret_noncrit <= !crit;
        idle();
        check("resume", 32'h00001234, resume_pc);
        @(posedge clk_sys);
        #1 check("core pc", 32'h00001234, core_pc);
        rd("restored", exc_ctx_pkg::SEL_STATE, 32'h00029000);
    endtask : t_entry
    task automatic fault(input exc_ctx_pkg::fault_kind_t k, input logic [5:0] f,
                         input logic hit, input logic [31:0] e);
        @(posedge clk_sys);
        fault_kind <= k; fault_ea <= 32'hA5A50003; ifetch_mcheck_hit <= hit;
        {illegal_op_flag, priv_op_flag, trap_hit_flag,
         store_fault_flag, zone_fault_flag, user0_fault_flag} <= f;
        idle();
        rd("syndrome", exc_ctx_pkg::SEL_SYND, e);
    endtask : fault
    task automatic t_syndrome(); // syndrome updates per cause
        wr(exc_ctx_pkg::SEL_SYND, 32'h8EC08000);
        fault(exc_ctx_pkg::FLT_PROGRAM, 6'b100000, 1'b0, 32'h88000000);
        fault(exc_ctx_pkg::FLT_DTLB, 6'b000000, 1'b0, 32'h80000000);
        rd("fault addr", exc_ctx_pkg::SEL_FADDR, 32'hA5A50003);
        wr(exc_ctx_pkg::SEL_SYND, 32'h00000000);
        fault(exc_ctx_pkg::FLT_DSTORE, 6'b000101, 1'b0, 32'h00808000);
        wr(exc_ctx_pkg::SEL_STATE, 32'h00001000);
        fault(exc_ctx_pkg::FLT_NONE, 6'b000000, 1'b1, 32'h80000000);
        wr(exc_ctx_pkg::SEL_STATE, 32'h00000000);
        wr(exc_ctx_pkg::SEL_SYND, 32'h00000000);
        fault(exc_ctx_pkg::FLT_DSTORE, 6'b000110, 1'b1, 32'h80C00000);
        fault(exc_ctx_pkg::FLT_ISTORE, 6'b000010, 1'b0, 32'h80400000);
        fault(exc_ctx_pkg::FLT_ALIGN, 6'b111111, 1'b0, 32'h80400000);
    endtask : t_syndrome
    task automatic t_modes(); // mode bits and request gating
        wr(exc_ctx_pkg::SEL_STATE, 32'h00028630);
        check("modes", 32'hF, modes);
        check("gates", reqs, gates);
    endtask : t_modes
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        resetn = 1'b0; reqs = '0; spr_sel = exc_ctx_pkg::SEL_STATE;
        fault_kind = exc_ctx_pkg::FLT_NONE;
        {spr_wr, spr_rd, take_noncrit, take_crit, take_is_mcheck, ret_noncrit, ret_crit} = '0;
        {ifetch_mcheck_hit, illegal_op_flag, priv_op_flag, trap_hit_flag} = '0;
        {store_fault_flag, zone_fault_flag, user0_fault_flag} = '0;
        {spr_wdata, take_pc, take_state_clr, fault_ea, take_vec_offset} = '0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        t_map();
        t_entry(1'b0);
        t_entry(1'b1);
        t_syndrome();
        t_modes();
        tally_and_finish();
    end
    // watchdog against a hang
    initial begin
        #1000000;
        miscompares++;
        tally_and_finish();
    end
endmodule : tb
